// ---- core/pfb_map.svh ----
// Constants for the procedure frame builder
`ifndef PFB_MAP_SVH
`define PFB_MAP_SVH
`define PFB_OPCODE       16'h7A05
`define PFB_TOP_EXT      4'hD
`define PFB_TOP_CMP      4'hE
`define PFB_TRAP_BIT     15
`define PFB_LOW_SPLIT    4'h8
`define PFB_LOW_BASE     5'h10
`define PFB_STEP_WORD    32'h00000002
`define PFB_STEP_LONG    32'h00000004
`define PFB_WORD_MASK    32'h0000FFFF
`define PFB_RST_WORD16   16'h0000
`define PFB_RST_WORD32   32'h00000000
`endif

// ---- core/pfb_pkg.sv ----
// Types for the procedure frame builder
package pfb_pkg;
  typedef enum logic [3:0] {
    PFB_IDLE   = 4'b0000,
    PFB_MASK   = 4'b0001,
    PFB_SIZE   = 4'b0010,
    PFB_SCAN   = 4'b0011,
    PFB_RDREG  = 4'b0100,
    PFB_PUSH   = 4'b0101,
    PFB_FP     = 4'b0110,
    PFB_XMASK  = 4'b0111,
    PFB_ZERO   = 4'b1000,
    PFB_FINISH = 4'b1001
  } pfb_state_t;
  typedef enum logic {
    PFB_SZ_WORD = 1'b0,
    PFB_SZ_LONG = 1'b1
  } pfb_size_t;
endpackage

// ---- core/pfb_enter.sv ----
// Procedure-entry sequencer: register saves, frame build, local space
//
// Operation
// [RULE1] Opcode word 7A05 is followed by a mask word, then a size word.
// [RULE2] Each mask bit set to one pushes its longword register.
// [RULE3] Top index 13 extended, 14 compact; saves run downward to 0.
// [RULE4] Bits 0-7 select register 2i+16; bits 8 up select 2i-16.
// [RULE5] Mask bit 15 selects no register; it is the new trap enable.
// [RULE6] Exit mask is entry mask with bit 15 set to old trap enable.
// [RULE7] Compact: after saves push word frame pointer, then exit mask.
// [RULE8] Compact: after exit mask push a zero word handler pointer.
// [RULE9] Extended: after saves push longword frame pointer, then mask.
// [RULE10] Extended: after exit mask push a zero longword.
// [RULE11] Frame pointer then takes the stack pointer, at handler slot.
// [RULE12] Compact: size word is added to the word stack pointer.
// [RULE13] Extended: size word is sign-extended before the add.
// [RULE14] Last step writes trap enable with entry mask bit 15.
// [RULE15] No condition flags change and no exception is raised.
`timescale 1ns/1ps
`include "pfb_map.svh"

module pfb_enter
  import pfb_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Instruction word stream
  input  wire logic        iw_valid,
  input  wire logic [15:0] iw_data,
  output logic             iw_ready,
  // Processor state at entry
  input  wire logic        extended_addressing_select,
  input  wire logic        overflow_trap_enable,
  input  wire logic [31:0] frame_pointer,
  input  wire logic [31:0] stack_pointer,
  // Register file read port, data in the same cycle as request
  output logic             rf_rd_req,
  output logic [4:0]       rf_rd_idx,
  input  wire logic [31:0] rf_rd_data,
  // Stack write port
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic             mem_long,
  input  wire logic        mem_ack,
  // Processor state updates
  output logic             fp_we,
  output logic [31:0]      fp_wdata,
  output logic             sp_we,
  output logic [31:0]      sp_wdata,
  output logic             trap_we,
  output logic             trap_wdata,
  // Status
  output logic             busy,
  output logic             done
);

  pfb_state_t  state_q;
  pfb_state_t  ret_q;
  logic        ext_q;
  logic        old_trap_q;
  logic [15:0] mask_q;
  logic [15:0] siz_q;
  logic [3:0]  idx_q;
  logic [31:0] sp_q;
  logic [31:0] fp_q;
  logic [31:0] push_data_q;
  pfb_size_t   push_size_q;
  logic        iw_ready_q;
  logic        rf_rd_req_q;
  logic [4:0]  rf_rd_idx_q;
  logic        mem_req_q;
  logic [31:0] mem_addr_q;
  logic        fp_we_q;
  logic [31:0] fp_wdata_q;
  logic        sp_we_q;
  logic [31:0] sp_wdata_q;
  logic        trap_we_q;
  logic        trap_wdata_q;
  logic        done_q;
  logic        busy_q;

  logic [31:0] step;
  logic [31:0] siz_ext;
  logic [4:0]  reg_num;
  logic        iw_take;

  assign iw_take = iw_valid && iw_ready_q;
  assign step = (push_size_q == PFB_SZ_LONG) ? `PFB_STEP_LONG
                                             : `PFB_STEP_WORD;
  // Compact mode keeps the pointer within its 16-bit word
  assign siz_ext = ext_q ? {{16{siz_q[15]}}, siz_q}          // RULE13
                         : {`PFB_RST_WORD16, siz_q};          // RULE12

  // Register number from mask index
  always_comb
  begin
    if (idx_q < `PFB_LOW_SPLIT)
      reg_num = 5'({idx_q, 1'b0}) + `PFB_LOW_BASE;            // RULE4
    else
      reg_num = 5'({idx_q, 1'b0}) - `PFB_LOW_BASE;            // RULE4
  end

  // Sequencer
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q     <= PFB_IDLE;
      ret_q       <= PFB_IDLE;
      ext_q       <= 1'b0;
      old_trap_q  <= 1'b0;
      mask_q      <= `PFB_RST_WORD16;
      siz_q       <= `PFB_RST_WORD16;
      idx_q       <= 4'h0;
      sp_q        <= `PFB_RST_WORD32;
      fp_q        <= `PFB_RST_WORD32;
      push_data_q <= `PFB_RST_WORD32;
      push_size_q <= PFB_SZ_WORD;
      busy_q      <= 1'b0;
    end
    else
    begin
      case (state_q)
        PFB_IDLE:
        begin
          // Other opcodes are consumed and left to other units
          if (iw_take && iw_data == `PFB_OPCODE)               // RULE1
          begin
            state_q    <= PFB_MASK;
            busy_q     <= 1'b1;
            ext_q      <= extended_addressing_select;
            old_trap_q <= overflow_trap_enable;
            sp_q       <= stack_pointer;
            fp_q       <= frame_pointer;
          end
        end
        PFB_MASK:
        begin
          if (iw_take)                                         // RULE1
          begin
            mask_q  <= iw_data;
            state_q <= PFB_SIZE;
          end
        end
        PFB_SIZE:
        begin
          if (iw_take)                                         // RULE1
          begin
            siz_q   <= iw_data;
            idx_q   <= ext_q ? `PFB_TOP_EXT : `PFB_TOP_CMP;   // RULE3
            state_q <= PFB_SCAN;
          end
        end
        PFB_SCAN:
        begin
          // One index per cycle; bit 15 is never scanned
          if (mask_q[idx_q])                                   // RULE2
            state_q <= PFB_RDREG;
          else if (idx_q == 4'h0)
            state_q <= PFB_FP;
          else
            idx_q <= idx_q - 4'h1;                             // RULE3
        end
        PFB_RDREG:
        begin
          if (rf_rd_req_q)
          begin
            push_data_q <= rf_rd_data;
            push_size_q <= PFB_SZ_LONG;
            state_q     <= PFB_PUSH;
            ret_q       <= (idx_q == 4'h0) ? PFB_FP : PFB_SCAN;
            if (idx_q != 4'h0)
              idx_q <= idx_q - 4'h1;                           // RULE3
          end
        end
        PFB_FP:
        begin
          push_data_q <= ext_q ? fp_q : (fp_q & `PFB_WORD_MASK);
          push_size_q <= ext_q ? PFB_SZ_LONG : PFB_SZ_WORD;   // RULE7 RULE9
          state_q     <= PFB_PUSH;
          ret_q       <= PFB_XMASK;
        end
        PFB_XMASK:
        begin
          push_data_q <= {`PFB_RST_WORD16, old_trap_q,
                          mask_q[`PFB_TRAP_BIT-1:0]};          // RULE6
          push_size_q <= PFB_SZ_WORD;                          // RULE7 RULE9
          state_q     <= PFB_PUSH;
          ret_q       <= PFB_ZERO;
        end
        PFB_ZERO:
        begin
          push_data_q <= `PFB_RST_WORD32;                      // RULE8 RULE10
          push_size_q <= ext_q ? PFB_SZ_LONG : PFB_SZ_WORD;   // RULE8 RULE10
          state_q     <= PFB_PUSH;
          ret_q       <= PFB_FINISH;
        end
        PFB_PUSH:
        begin
          if (mem_req_q && mem_ack)
          begin
            sp_q    <= mem_addr_q;
            state_q <= ret_q;
          end
        end
        PFB_FINISH:
        begin
          state_q <= PFB_IDLE;
          busy_q  <= 1'b0;
        end
        default:
        begin
          state_q <= PFB_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Instruction stream handshake
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      iw_ready_q <= 1'b0;
    else if (iw_take && (state_q == PFB_SIZE))
      iw_ready_q <= 1'b0;
    else
      iw_ready_q <= (state_q == PFB_IDLE) || (state_q == PFB_MASK)
                    || (state_q == PFB_SIZE);
  end

  // Register file read
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rf_rd_req_q <= 1'b0;
      rf_rd_idx_q <= 5'h00;
    end
    else
    begin
      rf_rd_req_q <= (state_q == PFB_SCAN) && mask_q[idx_q]; // RULE2
      if ((state_q == PFB_SCAN) && mask_q[idx_q])
        rf_rd_idx_q <= reg_num;                                // RULE4
    end
  end

  // Stack write: predecrement, request held until acknowledged
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_req_q  <= 1'b0;
      mem_addr_q <= `PFB_RST_WORD32;
    end
    else if (state_q == PFB_PUSH)
    begin
      if (!mem_req_q)
      begin
        mem_req_q  <= 1'b1;
        mem_addr_q <= ext_q ? (sp_q - step)
                            : ((sp_q - step) & `PFB_WORD_MASK);
      end
      else if (mem_ack)
        mem_req_q <= 1'b0;
    end
  end

  // Architectural updates, written together on the last cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      fp_we_q      <= 1'b0;
      fp_wdata_q   <= `PFB_RST_WORD32;
      sp_we_q      <= 1'b0;
      sp_wdata_q   <= `PFB_RST_WORD32;
      trap_we_q    <= 1'b0;
      trap_wdata_q <= 1'b0;
      done_q       <= 1'b0;
    end
    else
    begin
      fp_we_q   <= (state_q == PFB_FINISH);
      sp_we_q   <= (state_q == PFB_FINISH);
      trap_we_q <= (state_q == PFB_FINISH);
      // No flag or exception output exists; completion only signals done
      done_q    <= (state_q == PFB_FINISH);                   // RULE15
      if (state_q == PFB_FINISH)
      begin
        fp_wdata_q   <= sp_q;                                  // RULE11
        sp_wdata_q   <= ext_q ? (sp_q + siz_ext)               // RULE13
                              : ((sp_q + siz_ext) & `PFB_WORD_MASK); // RULE12
        trap_wdata_q <= mask_q[`PFB_TRAP_BIT];                 // RULE5 RULE14
      end
    end
  end

  assign iw_ready   = iw_ready_q;
  assign rf_rd_req  = rf_rd_req_q;
  assign rf_rd_idx  = rf_rd_idx_q;
  assign mem_req    = mem_req_q;
  assign mem_addr   = mem_addr_q;
  assign mem_wdata  = push_data_q;
  assign mem_long   = push_size_q;
  assign fp_we      = fp_we_q;
  assign fp_wdata   = fp_wdata_q;
  assign sp_we      = sp_we_q;
  assign sp_wdata   = sp_wdata_q;
  assign trap_we    = trap_we_q;
  assign trap_wdata = trap_wdata_q;
  // Registered so the port never glitches on state decode
  assign busy       = busy_q;
  assign done       = done_q;

endmodule

// ---- verif/pfb_far_side.sv ----
// Register file and stack memory model for the sequencer's far side
`timescale 1ns/1ps
module pfb_far_side (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [2:0]  slow,
  input  wire logic        rf_rd_req,
  input  wire logic [4:0]  rf_rd_idx,
  output logic      [31:0] rf_rd_data,
  input  wire logic        mem_req,
  output logic             mem_ack
);
  logic [2:0]  cnt_q;
  logic [31:0] val;
  // Read answers in the request cycle; idle data is inverted
  // so a sample outside that cycle cannot match
  assign val = {11'h5A3, rf_rd_idx, 16'hB7C1};
  assign rf_rd_data = rf_rd_req ? val : ~val;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 3'h0;
      mem_ack <= 1'b0;
    end
    else
    begin
      cnt_q <= (mem_req && !mem_ack) ? cnt_q + 3'h1 : 3'h0;
      mem_ack <= mem_req && !mem_ack && cnt_q == slow;
    end
  end
endmodule

// ---- verif/pfb_enter_props.sv ----
// Checker for the procedure-entry sequencer ports
`timescale 1ns/1ps
module pfb_enter_props (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        iw_valid,
  input wire logic [15:0] iw_data,
  input wire logic        iw_ready,
  input wire logic        extended_addressing_select,
  input wire logic        rf_rd_req,
  input wire logic [4:0]  rf_rd_idx,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_long,
  input wire logic        mem_ack,
  input wire logic        fp_we,
  input wire logic [31:0] fp_wdata,
  input wire logic        sp_we,
  input wire logic        trap_we,
  input wire logic        busy,
  input wire logic        done
);
  logic [31:0] last_q;
  logic        seen_q;
  logic        take;
  assign take = mem_req && mem_ack;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      last_q <= 32'h00000000;
      seen_q <= 1'b0;
    end
    else
    begin
      if (take)
        last_q <= mem_addr;
      seen_q <= !done && (seen_q || take);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  start_busy_a:
    assert property (iw_valid && iw_ready && !busy && iw_data == 16'h7A05
      |=> busy) else $error("opcode did not start");
  drop_word_a:
    assert property (iw_valid && iw_ready && !busy && iw_data != 16'h7A05
      |=> !busy) else $error("stray word started");
  reg_index_a:
    assert property (rf_rd_req |-> !rf_rd_idx[0] && rf_rd_idx != 5'h0E)
    else $error("bad register index");
  ext_top_a:
    assert property (rf_rd_req && extended_addressing_select
      |-> rf_rd_idx != 5'h0C) else $error("index 14 read in extended");
  push_hold_a:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_wdata) && $stable(mem_long)) else $error("push moved");
  push_step_a:
    assert property (take && seen_q |-> mem_addr[15:0] == last_q[15:0] -
      (mem_long ? 16'h0004 : 16'h0002)) else $error("push address step");
  frame_slot_a:
    assert property (done |-> fp_we && sp_we && trap_we
      && fp_wdata == last_q) else $error("frame pointer not at slot");
  zero_slot_a:
    assert property (take ##2 done |-> $past(mem_wdata, 2) == 32'h00000000)
    else $error("handler slot not zero");
  cover property (done && extended_addressing_select);
  cover property (done && !extended_addressing_select);
  cover property (mem_req && !mem_ack ##1 take);
endmodule
bind pfb_enter pfb_enter_props u_props (.clock, .resetn, .iw_valid,
  .iw_data, .iw_ready, .extended_addressing_select, .rf_rd_req,
  .rf_rd_idx, .mem_req, .mem_addr, .mem_wdata, .mem_long, .mem_ack,
  .fp_we, .fp_wdata, .sp_we, .trap_we, .busy, .done);

// ---- verif/tb_pfb_enter.sv ----
// Random and corner-case bench for the procedure-entry sequencer
`timescale 1ns/1ps
module tb_pfb_enter;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        iw_valid = 1'b0;
  logic [15:0] iw_data = 16'h0000;
  logic        ext = 1'b0;
  logic        trap = 1'b0;
  logic [31:0] fp = 32'h00000000;
  logic [31:0] sp = 32'h00000000;
  logic [2:0]  slow = 3'h0;
  logic        iw_ready, rf_rd_req, mem_req, mem_long, mem_ack;
  logic        fp_we, sp_we, trap_we, trap_wdata, busy, done;
  logic [4:0]  rf_rd_idx;
  logic [31:0] rf_rd_data, mem_addr, mem_wdata, fp_wdata, sp_wdata;
  logic [31:0] lfsr = 32'hBA1C14C7;
  logic [31:0] r, r2;
  logic [64:0] got[$];
  int          n_errors = 0;
  int          checks = 0;
  always #2.5 clock = ~clock;
  always @(negedge clock)
    if (mem_req && mem_ack)
      got.push_back({mem_long, mem_addr, mem_wdata});
  pfb_enter DUT (.clock, .resetn, .iw_valid, .iw_data, .iw_ready,
    .extended_addressing_select(ext), .overflow_trap_enable(trap),
    .frame_pointer(fp), .stack_pointer(sp), .rf_rd_req, .rf_rd_idx,
    .rf_rd_data, .mem_req, .mem_addr, .mem_wdata, .mem_long, .mem_ack,
    .fp_we, .fp_wdata, .sp_we, .sp_wdata, .trap_we, .trap_wdata, .busy,
    .done);
  pfb_far_side u_far (.clock, .resetn, .slow, .rf_rd_req, .rf_rd_idx,
    .rf_rd_data, .mem_req, .mem_ack);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Compact pointers wrap in 16 bits
  function automatic logic [31:0] nxt(input logic [31:0] a, input logic e,
                                      input logic [15:0] n);
    return e ? a - {16'h0000, n} : {16'h0000, a[15:0] - n};
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  // Word pushes carry meaning in the low half only
  task automatic exp_push(input logic l, input logic [31:0] a, d);
    logic [64:0] g;
    g = got.size() > 0 ? got.pop_front() : 65'bx;
    chk(g[64] === l && g[63:32] === a && g[15:0] === d[15:0], "push");
    if (l)
      chk(g[31:16] === d[31:16], "push high half");
  endtask
  task automatic send(input logic [15:0] w);
    @(negedge clock);
    iw_valid = 1'b1;
    iw_data = w;
    // Ready is looked at where it stands, ahead of the taking edge
    while (iw_ready !== 1'b1)
      @(negedge clock);
    @(posedge clock);
  endtask
  task automatic run(input logic e, t, input logic [31:0] f, s,
                     input logic [15:0] m, z);
    logic [31:0] a;
    int          i;
    @(negedge clock);
    ext = e;
    trap = t;
    fp = e ? f : {16'h0000, f[15:0]};
    sp = e ? s : {16'h0000, s[15:0]};
    a = sp;
    got.delete();
    send(16'h7A05);
    send(m);
    send(z);
    @(negedge clock);
    iw_valid = 1'b0;
    for (i = 0; i < 600 && done !== 1'b1; i++)
      @(negedge clock);
    for (i = e ? 13 : 14; i >= 0; i--)
      if (m[i])
      begin
        a = nxt(a, e, 16'h0004);
        r = {11'h5A3, 5'(i < 8 ? 2 * i + 16 : 2 * i - 16), 16'hB7C1};
        exp_push(1'b1, a, r);
      end
    a = nxt(a, e, e ? 16'h0004 : 16'h0002);
    exp_push(e, a, fp);
    a = nxt(a, e, 16'h0002);
    exp_push(1'b0, a, {16'h0000, t, m[14:0]});
    a = nxt(a, e, e ? 16'h0004 : 16'h0002);
    exp_push(e, a, 32'h00000000);
    chk(got.size() == 0, "extra push");
    chk(fp_we === 1'b1 && fp_wdata === a, "frame pointer");
    r = e ? a + {{16{z[15]}}, z} : {16'h0000, a[15:0] + z};
    chk(sp_we === 1'b1 && sp_wdata === r, "stack pointer");
    chk(trap_we === 1'b1 && trap_wdata === m[15], "trap");
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    send(16'h7A06);
    @(negedge clock);
    chk(busy === 1'b0, "stray word started");
    run(1'b0, 1'b1, 32'h00001234, 32'h00000006, 16'hFFFF, 16'hFFF0);
    run(1'b1, 1'b0, 32'h89ABCDEF, 32'h00001000, 16'hFFFF, 16'h8000);
    run(1'b1, 1'b1, 32'h00000000, 32'h00000100, 16'h0000, 16'h7FFF);
    run(1'b0, 1'b0, 32'h0000FFFF, 32'h0000FFFE, 16'h8081, 16'h0000);
    repeat (30)
    begin
      r2 = rnd();
      slow = r2[4:2];
      run(r2[0], r2[1], rnd(), rnd(), r2[31:16], r2[20:5]);
    end
    report_and_stop();
  end
endmodule
